// >>> ability_checker.sv
`timescale 1ns/1ps
`include "fiber_autoneg_map.svh"
module ability_checker (
  input logic        core_clk,
  input logic        rst,
  input logic        clk_en,
  input logic [4:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        copper_link_up,
  input logic        copper_full_duplex,
  input logic [1:0]  copper_speed,
  input logic        tx_pause_en,
  input logic        rx_pause_en,
  input logic        fiber_media_active
);
  logic [1:0] mode_reg;
  logic       fwd_reg;
  // A low clock enable freezes the block, so strobes in those cycles are not taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {fwd_reg, mode_reg} <= 3'h5;
    end else if (clk_en && reg_wr && reg_addr == `FIBER_CTRL_OFS) begin
      {fwd_reg, mode_reg} <= {reg_wdata[7], reg_wdata[1:0]};
    end
  end
  wire       sys = clk_en && reg_rd && reg_addr == `ADV_WORD_OFS && mode_reg == 2'h2;
  wire       med = clk_en && reg_rd && reg_addr == `ADV_WORD_OFS && mode_reg == 2'h3;
  wire       prt = clk_en && reg_rd && reg_addr == `PARTNER_ABILITY_OFS && mode_reg == 2'h2;
  wire [2:0] fwd = {tx_pause_en, rx_pause_en, fiber_media_active} & {3{fwd_reg}};
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  link_bit_a: assert property ($past(sys) |-> reg_rdata[15] == $past(copper_link_up)) else $error("link");
  duplex_bit_a: assert property ($past(sys) |-> reg_rdata[12] == $past(copper_full_duplex))
    else $error("duplex");
  speed_field_a: assert property ($past(sys) |-> reg_rdata[11:10] == $past(copper_speed))
    else $error("speed");
  pause_bits_a: assert property ($past(sys) |-> reg_rdata[9:8] == $past(fwd[2:1])) else $error("pause");
  media_bit_a: assert property ($past(sys) |-> reg_rdata[7] == $past(fwd[0])) else $error("media");
  media_word_a: assert property ($past(med) |-> reg_rdata == `MEDIA_ADV_CONST) else $error("word");
  sys_view_a: assert property ($past(prt) |-> !reg_rdata[15]) else $error("view");
  idle_zero_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("idle");
endmodule

// >>> code_word_if.sv
`timescale 1ns/1ps
interface code_word_if;
  logic                        link_up;
  logic                        page_valid;
  fiber_autoneg_pkg::word_t    page_word;
  fiber_autoneg_pkg::word_t    partner_word;

  modport capture (
    input  link_up,
    input  page_valid,
    input  page_word,
    output partner_word
  );

  modport owner (
    output link_up,
    output page_valid,
    output page_word,
    input  partner_word
  );
endinterface

// >>> fiber_autoneg_ability_regs.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "fiber_autoneg_map.svh"
// What this block does
// - SGMII system: advertised bit 15 shows copper link up.
// - SGMII system: advertised bit 12 shows resolved copper duplex.
// - SGMII system: advertised bits 11:10 show resolved copper speed.
// - SGMII system: advertised pause bits 9 and 8 show enables, zero without status forwarding.
// - SGMII system: advertised bit 7 shows active media, zero without status forwarding.
// - SGMII media: advertised word always reads 0x0001.
// - Fiber mode field picks the partner ability layout.
// - Partner bits clear on link down, load on each base page.
// - 1000BASE-X: partner bit 15 copies received next page bit.
// - Partner bit 14 copies received acknowledge in 1000BASE-X and both SGMII modes.
// - 1000BASE-X: partner bits 13:12 carry remote fault code.
// - 1000BASE-X: partner bits 8:7 carry received pause code.
// - 1000BASE-X: partner bits 6 and 5 copy duplex abilities.
// - SGMII media: partner bit 15 copies partner copper link.
// - SGMII media: partner bit 12 copies partner duplex.
// - SGMII media: partner bits 11:10 copy partner speed.
module fiber_autoneg_ability_regs #(
  parameter int ADDR_W = 5
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [15:0]               reg_rdata,
  input  wire logic                      copper_link_up,
  input  wire logic                      copper_full_duplex,
  input  wire logic [1:0]                copper_speed,
  input  wire logic                      tx_pause_en,
  input  wire logic                      rx_pause_en,
  input  wire logic                      fiber_media_active,
  input  wire logic                      fiber_link_up,
  input  wire logic                      page_rx_valid,
  input  wire logic [15:0]               page_rx_word
);

  // Elaboration-time check: the control word at 0x10 needs five address bits
  if (ADDR_W < 5) begin
    $error("ADDR_W must be at least 5");
  end

  code_word_if cw ();

  fiber_autoneg_pkg::fiber_mode_e  mode_reg;
  fiber_autoneg_pkg::fiber_mode_e  mode_next;
  logic                            fwd_reg;
  logic                            fwd_next;
  logic [15:0]                     rdata_reg;
  logic [15:0]                     rdata_next;
  fiber_autoneg_pkg::word_t        adv_word;
  fiber_autoneg_pkg::word_t        partner_view;

  assign cw.link_up    = fiber_link_up;
  assign cw.page_valid = page_rx_valid;
  assign cw.page_word  = page_rx_word;

  partner_capture u_capture (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .cw       (cw)
  );

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    addr_hit = (a == ADDR_W'(ofs));
  endfunction

  // Forwarded status bits all share one gate
  function automatic logic fwd_gate(input logic fwd, input logic bit_in);
    fwd_gate = fwd & bit_in;
  endfunction

  always_comb begin
    adv_word = `WORD_RST;
    case (mode_reg)
      fiber_autoneg_pkg::MODE_SGMII_SYSTEM: begin
        adv_word[6:0]                 = `ADV_LOW_FIXED;
        adv_word[`ADV_LINK_BIT]       = copper_link_up;
        adv_word[`ADV_DUPLEX_BIT]     = copper_full_duplex;
        adv_word[`ADV_SPEED_LSB +: 2] = copper_speed;
        adv_word[`ADV_TX_PAUSE_BIT]   = fwd_gate(fwd_reg, tx_pause_en);
        adv_word[`ADV_RX_PAUSE_BIT]   = fwd_gate(fwd_reg, rx_pause_en);
        adv_word[`ADV_MEDIA_BIT]      = fwd_gate(fwd_reg, fiber_media_active);
      end
      fiber_autoneg_pkg::MODE_SGMII_MEDIA: begin
        adv_word = `MEDIA_ADV_CONST;
      end
      default: begin
        adv_word = `WORD_RST;
      end
    endcase
  end

  // Capture keeps the raw word; each layout shows only its own fields
  always_comb begin
    case (mode_reg)
      fiber_autoneg_pkg::MODE_BASEX: begin
        partner_view = cw.partner_word & `BASEX_PARTNER_MASK;
      end
      fiber_autoneg_pkg::MODE_SGMII_SYSTEM: begin
        partner_view = cw.partner_word & `SYS_PARTNER_MASK;
      end
      fiber_autoneg_pkg::MODE_SGMII_MEDIA: begin
        partner_view = cw.partner_word & `MEDIA_PARTNER_MASK;
      end
      default: begin
        partner_view = `WORD_RST;
      end
    endcase
  end

  always_comb begin
    mode_next  = mode_reg;
    fwd_next   = fwd_reg;
    rdata_next = 16'h0000;
    // Only the control word accepts writes; the ability words ignore them
    if (reg_wr && addr_hit(reg_addr, `FIBER_CTRL_OFS)) begin
      mode_next = fiber_autoneg_pkg::fiber_mode_e'(reg_wdata[`FIBER_MODE_MSB:`FIBER_MODE_LSB]);
      fwd_next  = reg_wdata[`STATUS_FWD_BIT];
    end
    // Reads only select data, nothing is cleared by them
    if (reg_rd) begin
      if (addr_hit(reg_addr, `ADV_WORD_OFS)) begin
        rdata_next = adv_word;
      end else if (addr_hit(reg_addr, `PARTNER_ABILITY_OFS)) begin
        rdata_next = partner_view;
      end else if (addr_hit(reg_addr, `FIBER_CTRL_OFS)) begin
        rdata_next[`FIBER_MODE_MSB:`FIBER_MODE_LSB] = mode_reg;
        rdata_next[`STATUS_FWD_BIT]                 = fwd_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg  <= fiber_autoneg_pkg::fiber_mode_e'(`FIBER_MODE_RST);
      fwd_reg   <= `STATUS_FWD_RST;
      rdata_reg <= 16'h0000;
    end else if (clk_en) begin
      mode_reg  <= mode_next;
      fwd_reg   <= fwd_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// >>> fiber_autoneg_map.svh
`ifndef FIBER_AUTONEG_MAP_SVH
`define FIBER_AUTONEG_MAP_SVH

// Register offsets on the management port
`define ADV_WORD_OFS        5'h04
`define PARTNER_ABILITY_OFS 5'h05
`define FIBER_CTRL_OFS      5'h10

// Fiber control register fields
`define FIBER_MODE_LSB      0
`define FIBER_MODE_MSB      1
`define STATUS_FWD_BIT      7
`define FIBER_MODE_RST      2'h1
`define STATUS_FWD_RST      1'h1

// Advertised word fields, SGMII system layout and SGMII media word
`define ADV_LINK_BIT        15
`define ADV_DUPLEX_BIT      12
`define ADV_SPEED_LSB       10
`define ADV_TX_PAUSE_BIT    9
`define ADV_RX_PAUSE_BIT    8
`define ADV_MEDIA_BIT       7
`define ADV_LOW_FIXED       7'h01
`define MEDIA_ADV_CONST     16'h0001

// Partner ability masks per layout
`define BASEX_PARTNER_MASK  16'hffff
`define SYS_PARTNER_MASK    16'h7fff
`define MEDIA_PARTNER_MASK  16'hfc7f

`define WORD_RST            16'h0000

`endif

// >>> fiber_autoneg_pkg.sv
package fiber_autoneg_pkg;

  typedef logic [15:0] word_t;

  // Order matches the two-bit fiber mode field encoding
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_BASEX,
    MODE_SGMII_SYSTEM,
    MODE_SGMII_MEDIA
  } fiber_mode_e;

endpackage

// >>> link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
  input  logic        core_clk,
  output logic        link_up,
  output logic        page_valid,
  output logic [15:0] page_word
);
  initial {link_up, page_valid, page_word} = {2'h2, 16'h0000};
  // Word is inverted after the page so no stale value looks valid
  task automatic send(input logic [15:0] w);
    {page_valid, page_word} <= {1'b1, w};
    @(posedge core_clk);
    {page_valid, page_word} <= {1'b0, ~w};
  endtask
  task automatic set_link(input logic up);
    link_up <= up;
  endtask
endmodule

// >>> partner_capture.sv
`timescale 1ns/1ps
`include "fiber_autoneg_map.svh"
module partner_capture (
  input wire logic           core_clk,
  input wire logic           rst,
  input wire logic           clk_en,
  code_word_if.capture       cw
);

  fiber_autoneg_pkg::word_t  word_reg;
  fiber_autoneg_pkg::word_t  word_next;
  logic                      link_reg;
  logic                      link_next;

  // Pages arrive while the fiber link is still down, so only the falling edge clears
  always_comb begin
    link_next = cw.link_up;
    word_next = word_reg;
    if (link_reg && !cw.link_up) begin
      word_next = `WORD_RST;
    end
    // A page in the same cycle as the drop is kept: load wins over clear
    if (cw.page_valid) begin
      word_next = cw.page_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_reg <= `WORD_RST;
      link_reg <= 1'b0;
    end else if (clk_en) begin
      word_reg <= word_next;
      link_reg <= link_next;
    end
  end

  assign cw.partner_word = word_reg;

endmodule

// >>> tb_fiber_autoneg_ability_regs.sv
`timescale 1ns/1ps
bind fiber_autoneg_ability_regs ability_checker chk_i (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .copper_link_up(copper_link_up), .copper_full_duplex(copper_full_duplex), .copper_speed(copper_speed),
  .tx_pause_en(tx_pause_en), .rx_pause_en(rx_pause_en), .fiber_media_active(fiber_media_active));
module tb_fiber_autoneg_ability_regs;
  logic        core_clk, rst, clk_en, reg_wr, reg_rd, copper_link_up, copper_full_duplex;
  logic        tx_pause_en, rx_pause_en, fiber_media_active, fiber_link_up, page_rx_valid;
  logic [1:0]  copper_speed;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, page_rx_word;
  int          err_count = 0, num_checks = 0;
  fiber_autoneg_ability_regs DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .copper_link_up(copper_link_up), .copper_full_duplex(copper_full_duplex), .copper_speed(copper_speed),
    .tx_pause_en(tx_pause_en), .rx_pause_en(rx_pause_en), .fiber_media_active(fiber_media_active),
    .fiber_link_up(fiber_link_up), .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word));
  link_partner_model partner (.core_clk(core_clk), .link_up(fiber_link_up),
    .page_valid(page_rx_valid), .page_word(page_rx_word));
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Answer stands one cycle only, so it is taken mid-cycle
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
    @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (400) @(posedge core_clk);
    err_count++;
    close_out;
  end
  initial begin
    {rst, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h3, 23'h0};
    {copper_link_up, copper_full_duplex, copper_speed, tx_pause_en, rx_pause_en, fiber_media_active} = 7'h75;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(5'h10, 16'h0081);
    rd(5'h05, 16'h0000);
    partner.send(16'hf1e0);
    rd(5'h05, 16'hf1e0);
    wr(5'h05, 16'h0000);
    rd(5'h05, 16'hf1e0);
    wr(5'h10, 16'h0082);
    rd(5'h05, 16'h71e0);
    partner.send(16'h4001);
    rd(5'h05, 16'h4001);
    for (int s = 0; s < 3; s++) begin
      copper_speed <= s[1:0];
      rd(5'h04, {4'h9, s[1:0], 10'h281});
    end
    {copper_link_up, copper_full_duplex} <= 2'h0;
    wr(5'h10, 16'h0002);
    rd(5'h04, 16'h0801);
    wr(5'h10, 16'h0083);
    partner.send(16'hdfff);
    rd(5'h05, 16'hdc7f);
    wr(5'h04, 16'hffff);
    rd(5'h04, 16'h0001);
    // Frozen block must ignore both the control write and the page
    clk_en <= 1'b0;
    wr(5'h10, 16'h0081);
    partner.send(16'h0000);
    clk_en <= 1'b1;
    rd(5'h10, 16'h0083);
    rd(5'h05, 16'hdc7f);
    wr(5'h10, 16'h0000);
    rd(5'h05, 16'h0000);
    rd(5'h04, 16'h0000);
    wr(5'h10, 16'h0081);
    rd(5'h05, 16'hdfff);
    partner.set_link(1'b0);
    @(posedge core_clk);
    rd(5'h05, 16'h0000);
    // Negotiation runs before link up, so a page while down still loads
    partner.send(16'h0020);
    rd(5'h05, 16'h0020);
    rd(5'h1f, 16'h0000);
    close_out;
  end
endmodule
